// ### tcg_pkg.sv
// constants for the gated capture/compare timer: register map, fields, modes, reset values
// assumes a 32-bit AHB-Lite slave port and a single 125 MHz clock
// Overview of operation
// - mode field 4 selects capture mode watching the input pin
// - an input pin change of the kind picked by capture source select raises a capture event in hardware
// - next timer tick after capture copies count to hold register, sets flag
// - capture never halts or clears the count; rollover still detected
// - capture mode: tick after count equals compare reloads one, sets flag
// - capture and rollover both set the flag; irq only when enabled
// - software count value applies to first period only; later periods start at one
// - timer reset clears count to zero; reload of one from second period on
// - capture source select field in secondary control picks the capture event
// - mode field 5 selects compare mode; prescaler sets count rate
// - compare mode counts freely to 32/16-bit full scale, wraps to zero
// - compare mode: tick after match sets flag, timer stays enabled
// - compare period end: conflict resolved as free counting, no restart
// - compare period end toggles output; pin follows only when output enabled
// - mode field 6 selects gated mode, otherwise like continuous mode
// - gated mode counts only while input is at its active level
// - gated mode: tick after match reloads one, toggles output, sets flag
// - polarity field gives inactive input level and inactive output level
// - flag clears only on write of one; repeat event adds no interrupt
package tcg_pkg;
   localparam int DATA_W = 32;
   localparam int PRE_W = 16;
   // register byte offsets
   localparam logic [7:0] OFS_COUNT = 8'h00;
   localparam logic [7:0] OFS_LIMIT = 8'h04;
   localparam logic [7:0] OFS_HOLD = 8'h08;
   localparam logic [7:0] OFS_FLAG = 8'h0C;
   localparam logic [7:0] OFS_CTRL0 = 8'h10;
   localparam logic [7:0] OFS_CTRL1 = 8'h18;
   // primary control fields
   localparam int C0_MODE_LSB = 0;
   localparam int C0_PRES_LSB = 4;
   localparam int C0_POL_BIT = 8;
   localparam int C0_EN_BIT = 15;
   // secondary control fields
   localparam int C1_IEN_BIT = 0;
   localparam int C1_OEN_BIT = 1;
   localparam int C1_CAPSEL_LSB = 2;
   localparam int C1_W16_BIT = 4;
   localparam int FLAG_BIT = 0;
   // mode codes
   localparam logic [3:0] MODE_CAPTURE = 4'h4;
   localparam logic [3:0] MODE_COMPARE = 4'h5;
   localparam logic [3:0] MODE_GATED = 4'h6;
   // capture source select codes
   localparam logic [1:0] CAP_ANY = 2'h0;
   localparam logic [1:0] CAP_RISE = 2'h1;
   localparam logic [1:0] CAP_FALL = 2'h2;
   // count values
   localparam logic [31:0] CNT_RESET = 32'h0000_0000;
   localparam logic [31:0] CNT_RELOAD = 32'h0000_0001;
   localparam logic [31:0] FULL_32 = 32'hFFFF_FFFF;
   localparam logic [31:0] FULL_16 = 32'h0000_FFFF;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   typedef enum logic [1:0] {TCG_IDLE, TCG_RUN, TCG_OFF} tcg_run_type;
endpackage : tcg_pkg

// ### tcg_timer.sv
// timer with capture (4), compare (5) and gated (6) modes behind an AHB-Lite slave
// assumes one clock domain; timer input pin is asynchronous and synchronised here
`timescale 1ns/100ps
module tcg_timer import tcg_pkg::*; #(
   parameter int CNT_W = 32
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic tmr_in_i,
   output logic tmr_out_o,
   output logic irq_o
);
   logic [CNT_W-1:0] timer_count_value;
   logic [CNT_W-1:0] match_limit_value;
   logic [CNT_W-1:0] capture_hold_value;
   logic event_flag;
   logic [15:0] ctrl0;
   logic [4:0] ctrl1;
   logic [PRE_W-1:0] pre_cnt;
   logic [2:0] pin_sync;
   logic pin_lvl;
   logic cap_pend;
   logic out_state;
   tcg_run_type run_state;
   // bus data-phase state
   logic dp_write;
   logic [7:0] dp_addr;
   // decoded fields
   logic [3:0] mode;
   logic [3:0] pres;
   logic pol, en, int_en, out_en, w16;
   logic [1:0] capsel;
   logic tick, at_match, gate_active, cap_evt, period_evt;
   logic wr_count, wr_flag1;
   logic [CNT_W-1:0] full_scale;
   logic [PRE_W-1:0] pre_lim;
   logic [31:0] next_rdata;

   assign mode = ctrl0[C0_MODE_LSB +: 4];
   assign pres = ctrl0[C0_PRES_LSB +: 4];
   assign pol = ctrl0[C0_POL_BIT];
   assign en = ctrl0[C0_EN_BIT];
   assign int_en = ctrl1[C1_IEN_BIT];
   assign out_en = ctrl1[C1_OEN_BIT];
   assign capsel = ctrl1[C1_CAPSEL_LSB +: 2];
   assign w16 = ctrl1[C1_W16_BIT];

   // run state follows enable and mode; other modes are not served here and leave the timer idle
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         run_state <= TCG_OFF;
      end else if (!en) begin
         run_state <= TCG_OFF;
      end else begin
         case (mode)
            MODE_CAPTURE, MODE_COMPARE, MODE_GATED: run_state <= TCG_RUN;
            default: run_state <= TCG_IDLE;
         endcase
      end
   end

   // prescaler: one timer tick every 2^pres clocks
   assign pre_lim = PRE_W'((17'h1 << pres) - 17'h1);
   assign tick = (run_state == TCG_RUN) && en && (pre_cnt == pre_lim);
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pre_cnt <= '0;
      end else if (run_state != TCG_RUN || !en || pre_cnt == pre_lim) begin
         pre_cnt <= '0;
      end else begin
         pre_cnt <= pre_cnt + PRE_W'(1);
      end
   end

   // three-stage input synchroniser; a level counts once stages two and three agree
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_sync <= 3'h0;
      end else begin
         pin_sync <= {pin_sync[1:0], tmr_in_i};
      end
   end

   // filtered level; reset value is low, so a pin held high gives one early edge
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_lvl <= 1'b0;
      end else if (pin_sync[1] == pin_sync[2]) begin
         pin_lvl <= pin_sync[2];
      end
   end

   // capture source: any change, rising or falling edge of the filtered level
   always_comb begin
      cap_evt = 1'b0;
      if (pin_sync[1] == pin_sync[2] && pin_sync[2] != pin_lvl) begin
         case (capsel)
            CAP_ANY: cap_evt = 1'b1;
            CAP_RISE: cap_evt = pin_sync[2];
            CAP_FALL: cap_evt = !pin_sync[2];
            default: cap_evt = 1'b0;
         endcase
      end
   end

   // active input level is the opposite of the polarity field
   assign gate_active = (pin_lvl != pol);
   assign at_match = (timer_count_value == match_limit_value);
   assign full_scale = w16 ? CNT_W'(FULL_16) : CNT_W'(FULL_32);

   // pending capture is served on the following timer tick
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cap_pend <= 1'b0;
      end else if (mode != MODE_CAPTURE || run_state != TCG_RUN) begin
         cap_pend <= 1'b0;
      end else if (tick) begin
         cap_pend <= cap_evt;
      end else if (cap_evt) begin
         cap_pend <= 1'b1;
      end
   end

   // period end: rollover, compare match or a served capture
   assign period_evt = tick && (at_match || (mode == MODE_CAPTURE && cap_pend));

   // capture hold register copies the running count, count itself untouched
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         capture_hold_value <= '0;
      end else if (tick && cap_pend && mode == MODE_CAPTURE) begin
         capture_hold_value <= timer_count_value;
      end
   end

   // bus access decode
   assign wr_count = dp_write && dp_addr == OFS_COUNT;
   assign wr_flag1 = dp_write && dp_addr == OFS_FLAG && hwdata_i[FLAG_BIT];

   // counter: software write first, then mode behaviour on each tick
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         timer_count_value <= CNT_W'(CNT_RESET);
      end else if (wr_count) begin
         timer_count_value <= hwdata_i[CNT_W-1:0];
      end else if (tick) begin
         case (mode)
            MODE_CAPTURE: begin
               if (at_match) begin
                  timer_count_value <= CNT_W'(CNT_RELOAD);
               end else begin
                  timer_count_value <= timer_count_value + CNT_W'(1);
               end
            end
            MODE_COMPARE: begin
               // free count to full scale, match does not restart the count
               if (timer_count_value >= full_scale) begin
                  timer_count_value <= '0;
               end else begin
                  timer_count_value <= timer_count_value + CNT_W'(1);
               end
            end
            MODE_GATED: begin
               if (at_match) begin
                  timer_count_value <= CNT_W'(CNT_RELOAD);
               end else if (gate_active) begin
                  timer_count_value <= timer_count_value + CNT_W'(1);
               end
            end
            default: timer_count_value <= timer_count_value;
         endcase
      end
   end

   // toggle state of the output; compare and gated modes only
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         out_state <= 1'b0;
      end else if (tick && at_match && (mode == MODE_COMPARE || mode == MODE_GATED)) begin
         out_state <= !out_state;
      end
   end

   // output pin rests at the polarity level while the output is disabled
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tmr_out_o <= 1'b0;
      end else begin
         tmr_out_o <= out_en ? (out_state ^ pol) : pol;
      end
   end

   // sticky event flag: a hardware set beats a same-cycle write-one clear
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         event_flag <= 1'b0;
      end else if (period_evt) begin
         event_flag <= 1'b1;
      end else if (wr_flag1) begin
         event_flag <= 1'b0;
      end
   end

   // interrupt request is a level, so an event while already set adds nothing
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= event_flag && int_en;
      end
   end

   // control and compare registers; software is expected to disable before changing them
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl0 <= '0;
         ctrl1 <= '0;
         match_limit_value <= '0;
      end else if (dp_write) begin
         case (dp_addr)
            OFS_CTRL0: ctrl0 <= hwdata_i[15:0];
            OFS_CTRL1: ctrl1 <= hwdata_i[4:0];
            OFS_LIMIT: match_limit_value <= hwdata_i[CNT_W-1:0];
            default: ctrl0 <= ctrl0;
         endcase
      end
   end

   // address phase is latched; data phase writes one cycle later, always zero wait
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
      end else begin
         dp_write <= hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && hwrite_i;
         dp_addr <= haddr_i[7:0];
      end
   end

   // read data is fetched in the address phase so hrdata comes from a flip-flop
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (haddr_i[7:0])
         OFS_COUNT: next_rdata = 32'(timer_count_value);
         OFS_LIMIT: next_rdata = 32'(match_limit_value);
         OFS_HOLD: next_rdata = 32'(capture_hold_value);
         OFS_FLAG: next_rdata = {31'h0, event_flag};
         OFS_CTRL0: next_rdata = {16'h0, ctrl0};
         OFS_CTRL1: next_rdata = {27'h0, ctrl1};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // unmapped addresses read zero and ignore writes, response always OKAY
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         hrdata_o <= 32'h0000_0000;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
         if (hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && !hwrite_i) begin
            hrdata_o <= next_rdata;
         end
      end
   end

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   a_capture_reload: assert property (
      tick && mode == MODE_CAPTURE && at_match && !wr_count |=> timer_count_value == CNT_W'(1))
      else $error("capture mode did not reload one after match");
   a_gated_reload: assert property (
      tick && mode == MODE_GATED && at_match && !wr_count |=> timer_count_value == CNT_W'(1)
      ##0 $changed(out_state))
      else $error("gated mode period end wrong");
   a_capture_copy: assert property (
      tick && cap_pend && mode == MODE_CAPTURE |=> capture_hold_value == $past(timer_count_value)
      ##0 event_flag)
      else $error("capture did not copy count or set flag");
   a_capture_keeps: assert property (
      tick && cap_pend && mode == MODE_CAPTURE && !at_match && !wr_count
      |=> timer_count_value == $past(timer_count_value) + CNT_W'(1))
      else $error("capture disturbed the count");
   a_gate_hold: assert property (
      tick && mode == MODE_GATED && !gate_active && !at_match && !wr_count
      |=> $stable(timer_count_value))
      else $error("gated count moved while inactive");
   a_compare_free: assert property (
      tick && mode == MODE_COMPARE && at_match && timer_count_value < full_scale && !wr_count
      |=> timer_count_value == $past(match_limit_value) + CNT_W'(1) ##0 event_flag)
      else $error("compare match did not count on freely");
   a_flag_sticky: assert property (
      event_flag && !wr_flag1 |=> event_flag)
      else $error("event flag cleared without write of one");
   a_irq_level: assert property (
      ##1 irq_o == $past(event_flag && int_en))
      else $error("irq does not follow flag and enable");
   a_sync_edge: assert property (
      cap_evt |-> pin_sync[1] == pin_sync[2] && $past(pin_sync[2], 2) != pin_sync[2]
      || $past(pin_lvl) != pin_sync[2])
      else $error("capture event without settled input");

   c_capture: cover property (tick && cap_pend && mode == MODE_CAPTURE);
   c_rollover: cover property (tick && at_match && mode == MODE_CAPTURE ##1 irq_o);
   c_compare_toggle: cover property (tick && at_match && mode == MODE_COMPARE && out_en);
   c_gate_stall: cover property (tick && mode == MODE_GATED && !gate_active);
   c_gated_reload: cover property (tick && at_match && mode == MODE_GATED);

   // compare mode: wrap at full scale and plain stepping below it
   a_compare_wrap: assert property (
      tick && mode == MODE_COMPARE && timer_count_value >= full_scale && !wr_count
      |=> timer_count_value == '0)
      else $error("compare mode did not wrap to zero");
   a_compare_step: assert property (
      tick && mode == MODE_COMPARE && timer_count_value < full_scale && !wr_count
      |=> timer_count_value == $past(timer_count_value) + CNT_W'(1))
      else $error("compare mode did not step by one");

   // output toggles on compare period end and follows only when enabled
   a_out_toggle: assert property (
      tick && at_match && mode == MODE_COMPARE |=> out_state != $past(out_state))
      else $error("compare period end did not toggle output");
   a_out_follow: assert property (
      out_en |=> tmr_out_o == ($past(out_state) ^ $past(pol)))
      else $error("output pin does not follow toggle state");
   a_out_idle: assert property (
      !out_en |=> tmr_out_o == $past(pol))
      else $error("disabled output not at inactive level");

   // every period end, capture included, raises the flag
   a_flag_set: assert property (
      period_evt |=> event_flag)
      else $error("period end did not set the flag");
   a_capture_period: assert property (
      tick && cap_pend && mode == MODE_CAPTURE |-> period_evt)
      else $error("served capture is not a period end");

   // supported modes with enable set put the timer into its running state
   a_run_modes: assert property (
      en && (mode == MODE_CAPTURE || mode == MODE_COMPARE || mode == MODE_GATED)
      |=> run_state == TCG_RUN)
      else $error("enabled timer mode did not start running");

   // gated mode counts while the input sits at its active level
   a_gate_count: assert property (
      tick && mode == MODE_GATED && gate_active && !at_match && !wr_count
      |=> timer_count_value == $past(timer_count_value) + CNT_W'(1))
      else $error("gated count did not advance while active");

   // edge-selected capture fires only on the chosen direction
   a_capture_rise: assert property (
      cap_evt && capsel == CAP_RISE |-> pin_sync[2])
      else $error("rise capture fired on a falling level");
   a_capture_fall: assert property (
      cap_evt && capsel == CAP_FALL |-> !pin_sync[2])
      else $error("fall capture fired on a rising level");

   // slave never stalls and never errors, so a master cannot hang on it
   a_bus_okay: assert property (
      hreadyout_o && !hresp_o)
      else $error("bus slave stalled or reported an error");
endmodule : tcg_timer

// ### tcg_pin_model.sv
// partner model: the external timer input pin seen by the timer
// assumes the bench calls set_level from its main sequence, one change at a time
`timescale 1ns/100ps
module tcg_pin_model (
   input wire logic clk_i,
   output logic pin_o
);
   int clk_cnt = 0;
   int last_chg = 0;
   initial pin_o = 1'b0;
   // free clock count, used to space level changes
   always @(posedge clk_i) begin
      clk_cnt <= clk_cnt + 1;
   end
   // changes closer than the input filter needs would be lost, so keep four clocks apart
   task automatic set_level(input logic v);
      while (clk_cnt - last_chg < 4) @(posedge clk_i);
      @(posedge clk_i);
      pin_o <= v;
      last_chg = clk_cnt;
   endtask : set_level
endmodule : tcg_pin_model

// ### tcg_timer_tb_top.sv
// self-checking bench for the capture, compare and gated timer
// assumes one slave on the bus, so hreadyout_o feeds hready_i back
`timescale 1ns/100ps
module tcg_timer_tb_top;
   import tcg_pkg::*;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic rd_dp = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] c0, lim, e;
   wire logic [31:0] hrdata;
   wire logic hready, hresp, tmr_in, tmr_out, irq;
   int mismatches = 0;
   int cmp_count = 0;
   int cyc = 0;
   int t0, t1;
   int rolls = 0;
   integer seed = 32'hEDF3C47B;
   logic [31:0] lo_q[$];
   logic [31:0] hi_q[$];
   string nm_q[$];

   tcg_timer tcg_timer_i (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .tmr_in_i(tmr_in), .tmr_out_o(tmr_out), .irq_o(irq));
   tcg_pin_model tcg_pin_model_i (.clk_i(clk_i), .pin_o(tmr_in));

   // 125 MHz clock and a cycle count for expected counter values
   always #4 clk_i = ~clk_i;
   always @(posedge clk_i) cyc <= cyc + 1;

   task automatic complete_run;
      if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : complete_run

   task automatic check_word(input string s, input logic [31:0] lo, hi, seen);
      cmp_count++;
      if ((seen >= lo && seen <= hi) !== 1'b1) begin
         $display("Error %s expected %h..%h seen %h", s, lo, hi, seen);
         mismatches++;
      end
   endtask : check_word

   task automatic check_bit(input string s, input logic exp, seen);
      cmp_count++;
      if (seen !== exp) begin
         $display("Error %s expected %b seen %b", s, exp, seen);
         mismatches++;
      end
   endtask : check_bit

   // read data is taken at the edge closing the data phase; oldest note is compared
   always @(posedge clk_i) begin
      if (rd_dp) begin
         if (nm_q.size() == 0) check_word("hrdata_o", 32'h0, 32'h0, 32'hX);
         else check_word(nm_q.pop_front(), lo_q.pop_front(), hi_q.pop_front(), hrdata);
      end
      rd_dp <= hsel & hready & (htrans == HTRANS_NONSEQ) & ~hwrite;
   end

   // one single word transfer; each phase held until hready is seen high
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      hsize <= 3'h2;
      htrans <= HTRANS_NONSEQ;
      do begin @(posedge clk_i); n++; end while (hready !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hwdata <= d;
      while (hready !== 1'b1 && n < 100) begin @(posedge clk_i); n++; end
      if (n < 100) @(posedge clk_i);
      while (hready !== 1'b1 && n < 100) begin @(posedge clk_i); n++; end
      if (n >= 50) begin mismatches++; complete_run(); end
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] lo, hi, input string s);
      lo_q.push_back(lo);
      hi_q.push_back(hi);
      nm_q.push_back(s);
      xfer(1'b0, a, 32'h0);
   endtask : rd

   task automatic wait_irq(input logic v, input int b);
      int n;
      n = 0;
      while (irq !== v && n < b) begin @(posedge clk_i); n++; end
      if (n >= b) begin mismatches++; complete_run(); end
   endtask : wait_irq

   // main sequence: reset, register map, then capture, compare and gated modes
   initial begin
      repeat (6) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      check_bit("irq_o", 1'b0, irq);
      check_bit("tmr_out_o", 1'b0, tmr_out);
      check_bit("hresp_o", 1'b0, hresp);
      rd(OFS_COUNT, CNT_RESET, CNT_RESET, "count");
      wr(OFS_HOLD, 32'h1234_5678);
      wr(8'h14, 32'hFFFF_FFFF);
      rd(OFS_HOLD, 32'h0, 32'h0, "hold");
      rd(8'h14, 32'h0, 32'h0, "unmapped");
      // capture on any input change, preloaded count for the first period
      c0 = $random(seed) & 32'hFF;
      wr(OFS_LIMIT, 32'hFFFF_0000);
      wr(OFS_COUNT, c0);
      wr(OFS_CTRL1, 32'h1);
      wr(OFS_CTRL0, 32'h8004);
      t0 = cyc;
      repeat (10 + ($random(seed) & 15)) @(posedge clk_i);
      tcg_pin_model_i.set_level(1'b1);
      e = c0 + 32'(cyc - t0);
      wait_irq(1'b1, 20);
      rolls = 0;
      rd(OFS_HOLD, e - 2, e + 10, "hold");
      rd(OFS_FLAG, 32'h1, 32'h1, "flag");
      e = c0 + 32'(cyc - t0);
      rd(OFS_COUNT, e - 3, e + 6, "count");
      wr(OFS_FLAG, 32'h1);
      repeat (2) @(posedge clk_i);
      check_bit("irq_o", 1'b0, irq);
      // rollover in capture mode reloads one
      wr(OFS_CTRL0, 32'h4);
      lim = 32'd24 + ($random(seed) & 15);
      wr(OFS_LIMIT, lim);
      wr(OFS_COUNT, lim - 3);
      wr(OFS_CTRL0, 32'h8004);
      wait_irq(1'b1, 20);
      rolls++;
      check_word("rollovers", 32'h1, 32'h1, 32'(rolls));
      rd(OFS_COUNT, CNT_RELOAD, 32'd12, "count");
      // compare mode runs through full scale and wraps, toggling the output
      wr(OFS_CTRL0, 32'h5);
      wr(OFS_CTRL1, 32'h3);
      wr(OFS_COUNT, 32'hFFFF_FFF0);
      wr(OFS_LIMIT, 32'hFFFF_FFF4);
      wr(OFS_FLAG, 32'h1);
      wr(OFS_CTRL0, 32'h8005);
      t0 = cyc;
      wait_irq(1'b1, 20);
      repeat (2) @(posedge clk_i);
      check_bit("tmr_out_o", 1'b1, tmr_out);
      repeat (30) @(posedge clk_i);
      e = 32'hFFFF_FFF0 + 32'(cyc - t0);
      rd(OFS_COUNT, e - 3, e + 6, "count");
      // gated mode, inactive level high, output and interrupt disabled
      wr(OFS_CTRL0, 32'h106);
      wr(OFS_CTRL1, 32'h0);
      repeat (2) @(posedge clk_i);
      check_bit("tmr_out_o", 1'b1, tmr_out);
      wr(OFS_COUNT, 32'h5);
      wr(OFS_LIMIT, 32'd200);
      wr(OFS_FLAG, 32'h1);
      wr(OFS_CTRL0, 32'h8106);
      repeat (12) @(posedge clk_i);
      rd(OFS_COUNT, 32'h5, 32'h5, "count");
      tcg_pin_model_i.set_level(1'b0);
      t0 = cyc;
      repeat (20) @(posedge clk_i);
      tcg_pin_model_i.set_level(1'b1);
      t1 = cyc - t0;
      repeat (10) @(posedge clk_i);
      rd(OFS_COUNT, 32'(5 + t1 - 3), 32'(5 + t1 + 3), "count");
      // gated rollover near the limit; flag rises but no request while disabled
      wr(OFS_CTRL0, 32'h106);
      wr(OFS_COUNT, 32'd198);
      wr(OFS_CTRL0, 32'h8106);
      tcg_pin_model_i.set_level(1'b0);
      repeat (20) @(posedge clk_i);
      tcg_pin_model_i.set_level(1'b1);
      repeat (8) @(posedge clk_i);
      rd(OFS_FLAG, 32'h1, 32'h1, "flag");
      check_bit("irq_o", 1'b0, irq);
      rd(OFS_COUNT, CNT_RELOAD, 32'd25, "count");
      repeat (3) @(posedge clk_i);
      complete_run();
   end
endmodule : tcg_timer_tb_top
